// file: adc_ctrl_pkg.sv
package adc_ctrl_pkg;

    // Bus geometry.
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;
    localparam int REG_W = 16;

    // Register indices and byte addresses.
    localparam logic [5:0] CFG_INDEX = 6'h01;
    localparam logic [5:0] OFF_INDEX = 6'h02;
    localparam logic [5:0] STATUS_INDEX = 6'h04;
    localparam logic [7:0] CFG_ADDR = {CFG_INDEX, 2'b00};
    localparam logic [7:0] OFF_ADDR = {OFF_INDEX, 2'b00};
    localparam logic [7:0] STATUS_ADDR = {STATUS_INDEX, 2'b00};

    // Configuration register fields.
    localparam int CFG_PHASE_BIT = 11;
    localparam int CFG_DDR_OFF_BIT = 10;
    localparam int CFG_SWING_BIT = 9;
    localparam int CFG_EDGE_BIT = 8;
    localparam int CFG_RSVD_MSB = 7;

    // Offset register fields.
    localparam int OFF_MAG_MSB = 15;
    localparam int OFF_MAG_LSB = 8;
    localparam int OFF_SIGN_BIT = 7;
    localparam int OFF_RSVD_MSB = 6;

    // Reset values and the decoded outputs that follow from them.
    localparam logic [15:0] CFG_RESET = 16'hB2FF;
    localparam logic [15:0] OFF_RESET = 16'h007F;
    localparam logic RST_SWING = CFG_RESET[CFG_SWING_BIT];
    localparam logic RST_DDR = ~CFG_RESET[CFG_DDR_OFF_BIT];
    localparam logic RST_DEMUX = RST_DDR & ~CFG_RESET[CFG_EDGE_BIT];
    localparam logic RST_SDR_RISE = CFG_RESET[CFG_DDR_OFF_BIT] & CFG_RESET[CFG_EDGE_BIT];
    localparam logic RST_PHASE90 = CFG_RESET[CFG_PHASE_BIT] & ~(RST_DDR & CFG_RESET[CFG_EDGE_BIT]);
    localparam logic [7:0] RST_OFF_MAG = OFF_RESET[OFF_MAG_MSB:OFF_MAG_LSB];
    localparam logic RST_OFF_NEG = OFF_RESET[OFF_SIGN_BIT];

    // Offset step of one code in microvolts.
    localparam logic signed [16:0] OFFSET_STEP_UV = 17'h0_00B0;

    // Bus response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {SEL_CFG, SEL_OFF, SEL_STATUS, SEL_NONE} reg_sel_t;

    function automatic reg_sel_t reg_sel(input logic [AXI_ADDR_W-1:0] addr);
        if (addr[7:2] == CFG_INDEX)
            return SEL_CFG;
        else if (addr[7:2] == OFF_INDEX)
            return SEL_OFF;
        else if (addr[7:2] == STATUS_INDEX)
            return SEL_STATUS;
        else
            return SEL_NONE;
    endfunction

    function automatic logic [15:0] merge_bytes(input logic [15:0] old,
                                                input logic [15:0] data,
                                                input logic [1:0] strb);
        return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
    endfunction

endpackage

// file: axil_write_port.sv
`timescale 1ns/1ps
module axil_write_port
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input logic clock_i,
    input logic rst_i,
    // Write address channel.
    input logic [AXI_ADDR_W-1:0] awaddr_i,
    input logic awvalid_i,
    output logic awready_o,
    // Write data channel.
    input logic [AXI_DATA_W-1:0] wdata_i,
    input logic [3:0] wstrb_i,
    input logic wvalid_i,
    output logic wready_o,
    // Write response channel.
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input logic bready_i,
    // Register side.
    input logic [1:0] wr_resp_i,
    output logic wr_en_o,
    output logic [AXI_ADDR_W-1:0] wr_addr_o,
    output logic [AXI_DATA_W-1:0] wr_data_o,
    output logic [3:0] wr_strb_o
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [AXI_ADDR_W-1:0] addr;
        logic [AXI_DATA_W-1:0] data;
        logic [3:0] strb;
        logic bvalid;
        logic [1:0] bresp;
    } wport_state_t;

    wport_state_t st;
    wport_state_t next_st;

    // Address and data are caught in either order; the commit waits for both.
    always_comb
    begin
        next_st = st;
        if (awvalid_i && st.awready)
        begin
            next_st.awready = 1'b0;
            next_st.aw_held = 1'b1;
            next_st.addr = awaddr_i;
        end
        if (wvalid_i && st.wready)
        begin
            next_st.wready = 1'b0;
            next_st.w_held = 1'b1;
            next_st.data = wdata_i;
            next_st.strb = wstrb_i;
        end
        if (st.aw_held && st.w_held)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_resp_i;
        end
        if (st.bvalid && bready_i)
        begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            st <= '{awready: 1'b1, wready: 1'b1, default: '0};
        else
            st <= next_st;
    end

    assign awready_o = st.awready;
    assign wready_o = st.wready;
    assign bvalid_o = st.bvalid;
    assign bresp_o = st.bresp;
    assign wr_en_o = st.aw_held & st.w_held;
    assign wr_addr_o = st.addr;
    assign wr_data_o = st.data;
    assign wr_strb_o = st.strb;

endmodule

// file: output_mode_decode.sv
`timescale 1ns/1ps
module output_mode_decode
    import adc_ctrl_pkg::*;
(
    // Stored register words.
    input logic [REG_W-1:0] cfg_i,
    input logic [REG_W-1:0] offset_i,
    // Decoded output bus modes.
    output logic swing_standard_o,
    output logic ddr_mode_o,
    output logic demux_mode_o,
    output logic sdr_rising_edge_o,
    output logic data_clock_phase_90_o,
    // Decoded offset.
    output logic [8:0] offset_code_o,
    output logic [16:0] offset_microvolt_o
);

    logic [8:0] mag_ext;
    logic signed [16:0] code_ext;

    assign swing_standard_o = cfg_i[CFG_SWING_BIT];
    assign ddr_mode_o = ~cfg_i[CFG_DDR_OFF_BIT];
    assign sdr_rising_edge_o = cfg_i[CFG_DDR_OFF_BIT] & cfg_i[CFG_EDGE_BIT];
    assign demux_mode_o = ~cfg_i[CFG_DDR_OFF_BIT] & ~cfg_i[CFG_EDGE_BIT];
    // The quarter-period clock phase is not offered in DDR non-demux mode.
    assign data_clock_phase_90_o = cfg_i[CFG_PHASE_BIT]
                                   & ~(~cfg_i[CFG_DDR_OFF_BIT] & cfg_i[CFG_EDGE_BIT]);

    assign mag_ext = {1'b0, offset_i[OFF_MAG_MSB:OFF_MAG_LSB]};
    // Sign-magnitude becomes a monotonic two's complement code.
    assign offset_code_o = offset_i[OFF_SIGN_BIT] ? 9'(-mag_ext) : mag_ext;
    assign code_ext = 17'($signed(offset_code_o));
    assign offset_microvolt_o = code_ext * OFFSET_STEP_UV;

endmodule

// file: adc_output_and_offset_control_regs.sv
`timescale 1ns/1ps
module adc_output_and_offset_control_regs
    import adc_ctrl_pkg::*;
(
    // Clock and reset.
    input logic clock_i,
    input logic rst_i,
    // Write address channel.
    input logic [AXI_ADDR_W-1:0] awaddr_i,
    input logic awvalid_i,
    output logic awready_o,
    // Write data channel.
    input logic [AXI_DATA_W-1:0] wdata_i,
    input logic [3:0] wstrb_i,
    input logic wvalid_i,
    output logic wready_o,
    // Write response channel.
    output logic [1:0] bresp_o,
    output logic bvalid_o,
    input logic bready_i,
    // Read address channel.
    input logic [AXI_ADDR_W-1:0] araddr_i,
    input logic arvalid_i,
    output logic arready_o,
    // Read data channel.
    output logic [AXI_DATA_W-1:0] rdata_o,
    output logic [1:0] rresp_o,
    output logic rvalid_o,
    input logic rready_i,
    // Output bus mode controls.
    output logic swing_standard_o,
    output logic ddr_mode_o,
    output logic demux_mode_o,
    output logic sdr_rising_edge_o,
    output logic data_clock_phase_90_o,
    // Channel offset controls.
    output logic [7:0] offset_magnitude_o,
    output logic offset_negative_o,
    output logic [8:0] offset_code_o,
    output logic [16:0] offset_microvolt_o
);

    typedef struct packed {
        logic [REG_W-1:0] cfg;
        logic [REG_W-1:0] offset;
        logic cfg_rsvd_ok;
        logic off_rsvd_ok;
        logic arready;
        logic rvalid;
        logic [AXI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
        logic swing;
        logic ddr;
        logic demux;
        logic sdr_rise;
        logic phase90;
        logic [7:0] mag;
        logic neg;
        logic [8:0] code;
        logic [16:0] uv;
    } top_state_t;

    localparam top_state_t RESET_STATE = '{
        cfg: CFG_RESET,
        offset: OFF_RESET,
        cfg_rsvd_ok: 1'b1,
        off_rsvd_ok: 1'b1,
        arready: 1'b1,
        swing: RST_SWING,
        ddr: RST_DDR,
        demux: RST_DEMUX,
        sdr_rise: RST_SDR_RISE,
        phase90: RST_PHASE90,
        mag: RST_OFF_MAG,
        neg: RST_OFF_NEG,
        default: '0
    };

    top_state_t st;
    top_state_t next_st;

    logic wr_en;
    logic [AXI_ADDR_W-1:0] wr_addr;
    logic [AXI_DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [1:0] wr_resp;
    reg_sel_t wr_sel;
    reg_sel_t rd_sel;
    logic [AXI_DATA_W-1:0] status_word;
    logic dec_swing;
    logic dec_ddr;
    logic dec_demux;
    logic dec_sdr_rise;
    logic dec_phase90;
    logic [8:0] dec_code;
    logic [16:0] dec_uv;

    axil_write_port u_write_port (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .awaddr_i(awaddr_i),
        .awvalid_i(awvalid_i),
        .awready_o(awready_o),
        .wdata_i(wdata_i),
        .wstrb_i(wstrb_i),
        .wvalid_i(wvalid_i),
        .wready_o(wready_o),
        .bresp_o(bresp_o),
        .bvalid_o(bvalid_o),
        .bready_i(bready_i),
        .wr_resp_i(wr_resp),
        .wr_en_o(wr_en),
        .wr_addr_o(wr_addr),
        .wr_data_o(wr_data),
        .wr_strb_o(wr_strb)
    );

    output_mode_decode u_decode (
        .cfg_i(st.cfg),
        .offset_i(st.offset),
        .swing_standard_o(dec_swing),
        .ddr_mode_o(dec_ddr),
        .demux_mode_o(dec_demux),
        .sdr_rising_edge_o(dec_sdr_rise),
        .data_clock_phase_90_o(dec_phase90),
        .offset_code_o(dec_code),
        .offset_microvolt_o(dec_uv)
    );

    assign wr_sel = reg_sel(wr_addr);
    assign rd_sel = reg_sel(araddr_i);
    assign status_word = {7'h00, st.code, 9'h000, st.off_rsvd_ok, st.cfg_rsvd_ok,
                          st.swing, st.phase90, st.sdr_rise, st.demux, st.ddr};

    // The status word is read-only, so writes to it are refused.
    always_comb
    begin
        if (wr_sel == SEL_NONE)
            wr_resp = RESP_DECERR;
        else if (wr_sel == SEL_STATUS)
            wr_resp = RESP_SLVERR;
        else
            wr_resp = RESP_OKAY;
    end

    always_comb
    begin
        next_st = st;
        next_st.swing = dec_swing;
        next_st.ddr = dec_ddr;
        next_st.demux = dec_demux;
        next_st.sdr_rise = dec_sdr_rise;
        next_st.phase90 = dec_phase90;
        next_st.mag = st.offset[OFF_MAG_MSB:OFF_MAG_LSB];
        next_st.neg = st.offset[OFF_SIGN_BIT];
        next_st.code = dec_code;
        next_st.uv = dec_uv;
        if (wr_en)
        begin
            if (wr_sel == SEL_CFG)
            begin
                next_st.cfg = merge_bytes(st.cfg, wr_data[15:0], wr_strb[1:0]);
                if (wr_strb[0])
                    next_st.cfg_rsvd_ok = &wr_data[CFG_RSVD_MSB:0];
            end
            else if (wr_sel == SEL_OFF)
            begin
                next_st.offset = merge_bytes(st.offset, wr_data[15:0], wr_strb[1:0]);
                if (wr_strb[0])
                    next_st.off_rsvd_ok = &wr_data[OFF_RSVD_MSB:0];
            end
        end
        if (st.rvalid && rready_i)
        begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end
        if (arvalid_i && st.arready)
        begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rdata = '0;
            next_st.rresp = RESP_OKAY;
            // Both control registers are write-only and read back as zero.
            if (rd_sel == SEL_STATUS)
                next_st.rdata = status_word;
            else if (rd_sel == SEL_NONE)
                next_st.rresp = RESP_DECERR;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            st <= RESET_STATE;
        else
            st <= next_st;
    end

    assign arready_o = st.arready;
    assign rvalid_o = st.rvalid;
    assign rdata_o = st.rdata;
    assign rresp_o = st.rresp;
    assign swing_standard_o = st.swing;
    assign ddr_mode_o = st.ddr;
    assign demux_mode_o = st.demux;
    assign sdr_rising_edge_o = st.sdr_rise;
    assign data_clock_phase_90_o = st.phase90;
    assign offset_magnitude_o = st.mag;
    assign offset_negative_o = st.neg;
    assign offset_code_o = st.code;
    assign offset_microvolt_o = st.uv;

    default clocking cb @(posedge clock_i);
    endclocking

    default disable iff (rst_i);

    property p_swing;
        (wr_en && wr_sel == SEL_CFG && wr_strb[1])
            |-> ##2 (swing_standard_o == $past(wr_data[CFG_SWING_BIT], 2));
    endproperty
    a_swing: assert property (p_swing)
        else $error("Swing output does not follow the written bit.");

    property p_sdr_edge;
        ##1 (sdr_rising_edge_o
             == ($past(st.cfg[CFG_DDR_OFF_BIT]) && $past(st.cfg[CFG_EDGE_BIT])));
    endproperty
    a_sdr_edge: assert property (p_sdr_edge)
        else $error("SDR edge select is wrong.");

    property p_demux;
        ddr_mode_o |-> (demux_mode_o == !$past(st.cfg[CFG_EDGE_BIT]));
    endproperty
    a_demux: assert property (p_demux)
        else $error("DDR demux mode does not follow the edge bit.");

    property p_phase;
        (ddr_mode_o && !demux_mode_o) |-> !data_clock_phase_90_o;
    endproperty
    a_phase: assert property (p_phase)
        else $error("Quarter phase selected in DDR non-demux mode.");

    property p_off_read;
        (arvalid_i && arready_o && araddr_i == OFF_ADDR)
            |=> (rvalid_o && rdata_o == 32'h0000_0000 && rresp_o == RESP_OKAY);
    endproperty
    a_off_read: assert property (p_off_read)
        else $error("Offset register did not read back as zero.");

    property p_off_write;
        (wr_en && wr_sel == SEL_OFF && wr_strb[1])
            |=> ##2 (offset_magnitude_o == $past(wr_data[OFF_MAG_MSB:OFF_MAG_LSB], 3))
                && bresp_o == RESP_OKAY;
    endproperty
    a_off_write: assert property (p_off_write)
        else $error("Offset write did not land.");

    property p_linear;
        !offset_negative_o |-> (offset_code_o == {1'b0, offset_magnitude_o});
    endproperty
    a_linear: assert property (p_linear)
        else $error("Positive offset code is not the magnitude.");

    property p_step;
        $signed(offset_microvolt_o) == $signed(offset_code_o) * OFFSET_STEP_UV;
    endproperty
    a_step: assert property (p_step)
        else $error("Offset is not code times the step.");

    property p_mag_reset;
        $past(rst_i) |-> (offset_magnitude_o == 8'h00)[*3];
    endproperty
    a_mag_reset: assert property (p_mag_reset)
        else $error("Offset magnitude not zero after reset.");

    property p_sign;
        (offset_negative_o && offset_magnitude_o != 8'h00)
            |-> ($signed(offset_code_o) < 0);
    endproperty
    a_sign: assert property (p_sign)
        else $error("Negative sign gave a non-negative code.");

    property p_ddr;
        ##1 (ddr_mode_o == !$past(st.cfg[CFG_DDR_OFF_BIT]));
    endproperty
    a_ddr: assert property (p_ddr)
        else $error("DDR mode does not follow the disable bit.");

endmodule

// file: axil_host_model.sv
`timescale 1ns/1ps
module axil_host_model
    import adc_ctrl_pkg::*;
(
    // Clock.
    input logic clock_i,
    // Write channels.
    output logic [AXI_ADDR_W-1:0] awaddr_o,
    output logic awvalid_o,
    input logic awready_i,
    output logic [AXI_DATA_W-1:0] wdata_o,
    output logic [3:0] wstrb_o,
    output logic wvalid_o,
    input logic wready_i,
    input logic [1:0] bresp_i,
    input logic bvalid_i,
    output logic bready_o,
    // Read channels.
    output logic [AXI_ADDR_W-1:0] araddr_o,
    output logic arvalid_o,
    input logic arready_i,
    input logic [AXI_DATA_W-1:0] rdata_i,
    input logic [1:0] rresp_i,
    input logic rvalid_i,
    output logic rready_o
);
    initial
    begin
        awaddr_o = 8'h00;
        awvalid_o = 1'b0;
        wdata_o = 32'h0000_0000;
        wstrb_o = 4'h0;
        wvalid_o = 1'b0;
        bready_o = 1'b1;
        araddr_o = 8'h00;
        arvalid_o = 1'b0;
        rready_o = 1'b1;
    end

    // Writes one word; reserved low bits of both registers are always sent as ones.
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data,
                             input logic [3:0] strb, output logic [1:0] resp);
        logic aw_hs;
        logic w_hs;
        logic b_hs;
        logic [15:0] word;
        word = data;
        if (addr == CFG_ADDR)
            word[7:0] = 8'hFF;
        if (addr == OFF_ADDR)
            word[6:0] = 7'h7F;
        b_hs = 1'b0;
        @(posedge clock_i);
        awaddr_o <= addr;
        awvalid_o <= 1'b1;
        wdata_o <= {16'h0000, word};
        wstrb_o <= strb;
        wvalid_o <= 1'b1;
        while (!b_hs)
        begin
            @(negedge clock_i);
            aw_hs = awvalid_o & awready_i;
            w_hs = wvalid_o & wready_i;
            b_hs = bready_o & bvalid_i;
            resp = bresp_i;
            @(posedge clock_i);
            if (aw_hs)
                awvalid_o <= 1'b0;
            if (w_hs)
                wvalid_o <= 1'b0;
        end
    endtask

    // Reads one word and returns its data and response.
    task automatic read_reg(input logic [7:0] addr, output logic [31:0] data,
                            output logic [1:0] resp);
        logic ar_hs;
        logic r_hs;
        r_hs = 1'b0;
        @(posedge clock_i);
        araddr_o <= addr;
        arvalid_o <= 1'b1;
        while (!r_hs)
        begin
            @(negedge clock_i);
            ar_hs = arvalid_o & arready_i;
            r_hs = rready_o & rvalid_i;
            data = rdata_i;
            resp = rresp_i;
            @(posedge clock_i);
            if (ar_hs)
                arvalid_o <= 1'b0;
        end
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench
    import adc_ctrl_pkg::*;
;
    logic clock_i, rst_i, awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i;
    logic arvalid_i, arready_o, rvalid_o, rready_i, offset_negative_o;
    logic swing_standard_o, ddr_mode_o, demux_mode_o, sdr_rising_edge_o, data_clock_phase_90_o;
    logic [7:0] awaddr_i, araddr_i, offset_magnitude_o;
    logic [31:0] wdata_i, rdata_o, rd;
    logic [3:0] wstrb_i;
    logic [1:0] bresp_o, rresp_o, resp;
    logic [8:0] offset_code_o;
    logic [16:0] offset_microvolt_o;
    logic [15:0] cfg;
    logic [8:0] offs [5];
    int error_cnt;
    int checks_done;

    adc_output_and_offset_control_regs dut (
        .clock_i(clock_i), .rst_i(rst_i), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
        .awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
        .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
        .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
        .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i),
        .swing_standard_o(swing_standard_o), .ddr_mode_o(ddr_mode_o),
        .demux_mode_o(demux_mode_o), .sdr_rising_edge_o(sdr_rising_edge_o),
        .data_clock_phase_90_o(data_clock_phase_90_o), .offset_magnitude_o(offset_magnitude_o),
        .offset_negative_o(offset_negative_o), .offset_code_o(offset_code_o),
        .offset_microvolt_o(offset_microvolt_o)
    );

    axil_host_model host (
        .clock_i(clock_i), .awaddr_o(awaddr_i), .awvalid_o(awvalid_i), .awready_i(awready_o),
        .wdata_o(wdata_i), .wstrb_o(wstrb_i), .wvalid_o(wvalid_i), .wready_i(wready_o),
        .bresp_i(bresp_o), .bvalid_i(bvalid_o), .bready_o(bready_i), .araddr_o(araddr_i),
        .arvalid_o(arvalid_i), .arready_i(arready_o), .rdata_i(rdata_o), .rresp_i(rresp_o),
        .rvalid_i(rvalid_o), .rready_o(rready_i)
    );

    initial
    begin
        clock_i = 1'b0;
        forever
            #10 clock_i = ~clock_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Compares the decoded output bus modes with those worked out from a config word.
    task automatic check_modes(input logic [15:0] c);
        logic ddr;
        ddr = ~c[10];
        check({27'h000_0000, swing_standard_o, ddr_mode_o, demux_mode_o, sdr_rising_edge_o,
               data_clock_phase_90_o}, {27'h000_0000, c[9], ddr, ddr & ~c[8], c[10] & c[8],
               c[11] & ~(ddr & c[8])}, "modes");
    endtask

    // Compares the offset outputs with a magnitude and sign.
    task automatic check_offset(input logic [7:0] mag, input logic neg);
        int v;
        int c;
        c = int'(mag);
        if (neg)
            c = -c;
        v = c * 32'h0000_00B0;
        check({23'h00_0000, offset_magnitude_o, offset_negative_o},
              {23'h00_0000, mag, neg}, "offset fields");
        check({23'h00_0000, offset_code_o}, {23'h00_0000, c[8:0]}, "offset code");
        check({15'h0000, offset_microvolt_o}, {15'h0000, v[16:0]}, "offset uV");
    endtask

    task automatic settle();
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
    endtask

    task automatic pulse_reset(input int n);
        @(posedge clock_i);
        rst_i <= 1'b1;
        repeat (n) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        end_sim();
    end

    initial
    begin
        error_cnt = 0;
        checks_done = 0;
        offs = '{9'h1FE, 9'h1FF, 9'h002, 9'h001, 9'h101};
        rst_i = 1'b1;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        check_modes(CFG_RESET);
        check_offset(8'h00, 1'b0);
        host.read_reg(OFF_ADDR, rd, resp);
        check(rd, 32'h0000_0000, "offset read");
        check({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY}, "offset rresp");
        host.read_reg(CFG_ADDR, rd, resp);
        check(rd, 32'h0000_0000, "config read");
        check({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY}, "config rresp");
        host.read_reg(8'h0C, rd, resp);
        check({30'h0000_0000, resp}, {30'h0000_0000, RESP_DECERR}, "unmapped rresp");
        check(rd, 32'h0000_0000, "unmapped read");
        for (int i = 0; i < 5; i++)
        begin
            host.write_reg(OFF_ADDR, {offs[i], 7'h00}, 4'h3, resp);
            check({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY}, "offset bresp");
            settle();
            check_offset(offs[i][8:1], offs[i][0]);
            check({27'h000_0000, awready_o, wready_o, arready_o, bvalid_o, rvalid_o},
                  {27'h000_0000, 5'h1C}, "bus idle");
        end
        host.write_reg(OFF_ADDR, 16'h3C00, 4'h2, resp);
        settle();
        check_offset(8'h3C, 1'b1);
        host.write_reg(OFF_ADDR, 16'h0000, 4'h1, resp);
        settle();
        check_offset(8'h3C, 1'b0);
        host.write_reg(8'h0C, 16'h0000, 4'h3, resp);
        check({30'h0000_0000, resp}, {30'h0000_0000, RESP_DECERR}, "unmapped bresp");
        host.write_reg(STATUS_ADDR, 16'h0000, 4'h3, resp);
        check({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR}, "status bresp");
        settle();
        check_offset(8'h3C, 1'b0);
        for (int k = 0; k < 16; k++)
        begin
            pulse_reset(2);
            check_offset(8'h00, 1'b0);
            check_modes(CFG_RESET);
            check({27'h000_0000, awready_o, wready_o, arready_o, bvalid_o, rvalid_o},
                  {27'h000_0000, 5'h1C}, "bus idle after reset");
            cfg = {4'hB, 4'(k), 8'hFF};
            host.write_reg(CFG_ADDR, cfg, 4'h3, resp);
            check({30'h0000_0000, resp}, {30'h0000_0000, RESP_OKAY}, "config bresp");
            settle();
            check_modes(cfg);
        end
        host.write_reg(OFF_ADDR, 16'h0580, 4'h3, resp);
        settle();
        host.read_reg(STATUS_ADDR, rd, resp);
        check(rd, 32'h01FB_007C, "status word");
        end_sim();
    end
endmodule
